// >>> iosb_regs.vh
// Register map, field positions and reset values of the I/O station block
`ifndef IOSB_REGS_VH
`define IOSB_REGS_VH

`define IOSB_ADDR_W 5
`define IOSB_OFF_STATUS 5'h00
`define IOSB_OFF_OWNED_LO 5'h04
`define IOSB_OFF_OWNED_HI 5'h08
`define IOSB_OFF_OUT_DATA 5'h0c
`define IOSB_OFF_CONTROL 5'h10
`define IOSB_OFF_DIR_MASK 5'h14

`define IOSB_CTRL_TX_EN 0
`define IOSB_CTRL_RX_EN 1
`define IOSB_CTRL_RESET 2'h3

`define IOSB_ST_ID_LSB 0
`define IOSB_ST_SRC_LSB 8
`define IOSB_ST_HALF 16
`define IOSB_ST_SWAP 17
`define IOSB_ST_LFS 18
`define IOSB_ST_SPLIT_LSB 20
`define IOSB_ST_OUT_SEEN 24

`define IOSB_MB_SPLIT_LSB 32
`define IOSB_MB_SWAP 35
`define IOSB_MB_LFS 39
`define IOSB_MB_HALF 40
`define IOSB_MB_SRC_LSB 41
`define IOSB_MB_POL_LSB 48

`define IOSB_SPLIT_ALL 3'h7
`define IOSB_PINS_PER_STEP 4

`endif

// >>> iosb_station.v
// I/O station: owned block assembly, output selection and pin direction
`timescale 1ns/100ps
// Operation
// - Internal input n goes to owned block bit n, bits 0 to 31.
// - Split select pins reported in bits 32 to 34.
// - Bit 35 is 1 when the low-active swap pin is Low.
// - Long-frame select pin reported inverted in bit 39.
// - Output-half select pin reported inverted in bit 40.
// - Six source station pins reported inverted in bits 41 to 46.
// - Eight polarity select pins reported in bits 48 to 55.
// - Bits 36 to 38, 47 and 56 to 63 always zero.
// - Input bits of pins configured as outputs read zero.
// - Every low-active configuration pin is inverted before storing.
// - Owned block is offered to every other station on the network.
// - Station id from six low-active pins, Low is 1, pin 5 MSB.
// - Station id latched only during reset, held until next reset.
// - Exactly one owned block, given by the station id.
// - Source block from six low-active pins, Low is 1, pin 5 MSB.
// - Half select picks upper or lower 32 bits for the outputs.
// - Source and half pins are used live, never latched.
// - Pin directions follow swap and split pins after the two synchroniser stages.
// - Split code n makes top 4n pins outputs, code 7 all; swap inverts.
// - Outputs refresh on a packet from the selected source station.
// - Outputs stay Low after reset until the first matching packet.
`include "iosb_regs.vh"

module iosb_station
(
   input wire ref_clk,
   input wire rst,
   input wire [`IOSB_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire [5:0] stationAddressPinsN,
   input wire [5:0] outputSourceStationPinsN,
   input wire outputHalfSelectN,
   input wire [2:0] directionSplitSelect,
   input wire directionSwapN,
   input wire [7:0] polaritySelect,
   input wire longFrameSelectN,
   input wire [31:0] externalIoIn,
   output wire [31:0] externalIoOut,
   output wire [31:0] externalIoOeN,
   input wire txRequest,
   output reg txValid,
   output reg [63:0] txBlock,
   output reg [5:0] txStationId,
   input wire rxValid,
   input wire [5:0] rxStationId,
   input wire [63:0] rxData,
   output reg [31:0] internalOutputs
);

   // Two-stage synchronisers; stage one feeds stage two only
   reg [5:0] saMeta;
   reg [5:0] saSync;
   reg [5:0] srcMeta;
   reg [5:0] srcSync;
   reg [4:0] cfgMeta;
   reg [4:0] cfgSync;
   reg [7:0] polMeta;
   reg [7:0] polSync;
   reg [31:0] ioMeta;
   reg [31:0] ioSync;

   reg [5:0] stationId;
   reg [1:0] control;
   reg outSeen;
   reg busAck;

   wire [2:0] splitCode;
   wire swapActive;
   wire halfUpper;
   wire longFrame;
   wire [5:0] sourceId;
   wire [31:0] outMask;
   wire [31:0] internalInputs;
   wire [63:0] ownedBlock;
   wire busReq;

   always @(posedge ref_clk)
   begin
      saMeta <= stationAddressPinsN;
      saSync <= saMeta;
      srcMeta <= outputSourceStationPinsN;
      srcSync <= srcMeta;
      cfgMeta <= {longFrameSelectN, outputHalfSelectN, directionSwapN, 1'b0, 1'b0};
      cfgSync <= cfgMeta;
      polMeta <= polaritySelect;
      polSync <= polMeta;
      ioMeta <= externalIoIn;
      ioSync <= ioMeta;
   end

   // Split code pins are not low active; sampled through their own stages
   reg [2:0] splitMeta;
   reg [2:0] splitSync;
   always @(posedge ref_clk)
   begin
      splitMeta <= directionSplitSelect;
      splitSync <= splitMeta;
   end

   assign splitCode = splitSync;
   assign swapActive = ~cfgSync[2];
   assign halfUpper = ~cfgSync[3];
   assign longFrame = ~cfgSync[4];
   assign sourceId = ~srcSync;

   // Direction mask: 1 marks an output pin
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1)
      begin : gDir
         wire topOut;
         assign topOut = (splitCode == `IOSB_SPLIT_ALL) ||
            ((gi / `IOSB_PINS_PER_STEP) >= (8 - splitCode));
         assign outMask[gi] = topOut ^ swapActive;
      end
   endgenerate

   assign internalInputs = ioSync & ~outMask;
   assign externalIoOut = internalOutputs;
   assign externalIoOeN = ~outMask;

   assign ownedBlock = {8'h00,
                        polSync,
                        1'b0,
                        sourceId,
                        halfUpper,
                        longFrame,
                        3'h0,
                        swapActive,
                        splitCode,
                        internalInputs};

   // Station id is caught while reset is held, so reset needs three edges
   always @(posedge ref_clk)
   begin
      if (rst)
         stationId <= ~saSync;
   end

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         txValid <= 1'b0;
         txBlock <= 64'h0;
         txStationId <= 6'h00;
      end
      else
      begin
         txValid <= txRequest & control[`IOSB_CTRL_TX_EN];
         txStationId <= stationId;
         if (txRequest)
            txBlock <= ownedBlock;
      end
   end

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         internalOutputs <= 32'h0;
         outSeen <= 1'b0;
      end
      else if (rxValid && control[`IOSB_CTRL_RX_EN] && rxStationId == sourceId)
      begin
         internalOutputs <= halfUpper ? rxData[63:32] : rxData[31:0];
         outSeen <= 1'b1;
      end
   end

   // Avalon slave: one wait cycle per access
   assign busReq = avs_read | avs_write;
   assign avs_waitrequest = busReq & ~busAck;

   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         busAck <= 1'b0;
         avs_readdata <= 32'h0;
         control <= `IOSB_CTRL_RESET;
      end
      else
      begin
         busAck <= busReq & ~busAck;
         if (avs_read && !busAck)
         begin
            avs_readdata <= 32'h0;
            if (avs_address == `IOSB_OFF_STATUS)
            begin
               avs_readdata[`IOSB_ST_ID_LSB +: 6] <= stationId;
               avs_readdata[`IOSB_ST_SRC_LSB +: 6] <= sourceId;
               avs_readdata[`IOSB_ST_HALF] <= halfUpper;
               avs_readdata[`IOSB_ST_SWAP] <= swapActive;
               avs_readdata[`IOSB_ST_LFS] <= longFrame;
               avs_readdata[`IOSB_ST_SPLIT_LSB +: 3] <= splitCode;
               avs_readdata[`IOSB_ST_OUT_SEEN] <= outSeen;
            end
            else if (avs_address == `IOSB_OFF_OWNED_LO)
               avs_readdata <= txBlock[31:0];
            else if (avs_address == `IOSB_OFF_OWNED_HI)
               avs_readdata <= txBlock[63:32];
            else if (avs_address == `IOSB_OFF_OUT_DATA)
               avs_readdata <= internalOutputs;
            else if (avs_address == `IOSB_OFF_CONTROL)
               avs_readdata[1:0] <= control;
            else if (avs_address == `IOSB_OFF_DIR_MASK)
               avs_readdata <= outMask;
         end
         if (avs_write && busAck && avs_address == `IOSB_OFF_CONTROL && avs_byteenable[0])
            control <= avs_writedata[1:0];
      end
   end

endmodule

// >>> iosb_chk_sva.sv
// Port checks for the I/O station
`timescale 1ns/100ps
module iosb_chk(
   input wire ref_clk,
   input wire rst,
   input wire [2:0] directionSplitSelect,
   input wire directionSwapN,
   input wire txValid,
   input wire [63:0] txBlock,
   input wire [5:0] txStationId,
   input wire rxValid,
   input wire [63:0] rxData,
   input wire [31:0] internalOutputs,
   input wire [31:0] externalIoOut,
   input wire [31:0] externalIoOeN
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   zero_bits_a: assert property (txValid |-> {txBlock[63:56],txBlock[47],txBlock[38:36]} == 0)
      else $error("unused bits");
   in_masked_a: assert property (txValid |-> (txBlock[31:0] & ~$past(externalIoOeN)) == 0)
      else $error("output pin bit");
   cfg_bits_a: assert property (txValid |-> txBlock[35:32] ==
      {~$past(directionSwapN, 3), $past(directionSplitSelect, 3)}) else $error("split bits");
   io_drive_a: assert property (externalIoOut == internalOutputs)
      else $error("pin drive");
   out_src_a: assert property ($changed(internalOutputs) |-> $past(rxValid) &&
      (internalOutputs == $past(rxData[31:0]) || internalOutputs == $past(rxData[63:32])))
      else $error("output source");
   rst_low_a: assert property ($fell(rst) |-> internalOutputs == 0 [*2])
      else $error("outputs after reset");
   id_held_a: assert property (!$past(rst, 2) |-> $stable(txStationId))
      else $error("id moved");
   all_out_a: assert property (!$past(rst, 3) && $past(directionSplitSelect, 2) == 3'h7
      |-> externalIoOeN == {32{~$past(directionSwapN, 2)}}) else $error("split 7");
   cover property (txValid);
   cover property ($changed(internalOutputs));
   cover property (externalIoOeN == 0);
endmodule
bind iosb_station iosb_chk u_chk(.*);

// >>> iosb_peer.sv
// Far-side station model
`timescale 1ns/100ps
module iosb_peer(
   input wire ref_clk,
   output reg txRequest,
   output reg rxValid,
   output reg [5:0] rxStationId,
   output reg [63:0] rxData
);
   initial {txRequest, rxValid, rxStationId, rxData} = 0;
   task send(input [5:0] id, input [63:0] dat, input t);
      {txRequest, rxValid, rxStationId, rxData} <= {t, 1'b1, id, dat};
      @(posedge ref_clk);
      // Released id and data lines never keep the old value
      {txRequest, rxValid, rxStationId, rxData} <= {2'h0, ~id, ~dat};
      @(negedge ref_clk);
   endtask
endmodule

// >>> tb_iosb_station.sv
// Self-checking bench for the I/O station
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH %0t value", $time); end end
module tb_iosb_station;
   logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic outputHalfSelectN, directionSwapN, longFrameSelectN, txRequest, txValid, rxValid;
   logic [4:0] avs_address = 0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 0, avs_readdata, externalIoIn, externalIoOut, externalIoOeN;
   logic [31:0] internalOutputs, q;
   logic [5:0] stationAddressPinsN, outputSourceStationPinsN, txStationId, rxStationId, id;
   logic [2:0] directionSplitSelect;
   logic [7:0] polaritySelect;
   logic [63:0] txBlock, rxData, d;
   integer seed = 36938, fails = 0, cmp_count = 0, i;
   iosb_station dut(.*);
   iosb_peer peer(.*);
   function automatic [63:0] expBlk();
      logic [31:0] m;
      m = directionSplitSelect == 3'h7 ? 32'hffffffff : ~(32'hffffffff >> 4 * directionSplitSelect);
      m = m ^ {32{~directionSwapN}};
      return {8'h0, polaritySelect, 1'b0, ~outputSourceStationPinsN, ~outputHalfSelectN,
         ~longFrameSelectN, 3'h0, ~directionSwapN, directionSplitSelect, externalIoIn & ~m};
   endfunction
   task avs(input w, input [4:0] a, input [31:0] dw);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, ~w, a, dw};
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge ref_clk);
      q = avs_readdata;
      {avs_write, avs_read} <= 2'h0;
      @(posedge ref_clk);
   endtask
   task resetRun();
      rst <= 1;
      repeat (6) @(posedge ref_clk);
      rst <= 0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(internalOutputs, 32'h0)
      `CHK(txStationId, ~stationAddressPinsN)
      @(posedge ref_clk);
   endtask
   task tally_and_finish();
      $display("fails=%0d compares=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial forever #5 ref_clk = ~ref_clk;
   initial
   begin
      #50000;
      fails++;
      tally_and_finish();
   end
   initial
   begin
      d = {$random(seed), $random(seed)};
      {stationAddressPinsN, directionSplitSelect, polaritySelect, longFrameSelectN} = d[17:0];
      {outputSourceStationPinsN, outputHalfSelectN, directionSwapN, externalIoIn} = d[63:24];
      resetRun();
      id = ~stationAddressPinsN;
      stationAddressPinsN <= ~stationAddressPinsN;
      avs(0, 5'h00, 0);
      `CHK(q[5:0], id)
      avs(0, 5'h1c, 0);
      `CHK(q, 32'h0)
      avs(1, 5'h10, 0);
      peer.send(6'h0, d, 1);
      `CHK(txValid, 1'b0)
      @(posedge ref_clk);
      avs(1, 5'h10, 32'h3);
      for (i = 0; i < 30; i++)
      begin
         d = {$random(seed), $random(seed)};
         if (i < 4) {d[11:9], d[62]} = {i[1] ? 3'h7 : 3'h0, i[0]};
         if (~d[17:12] == id) d[12] = ~d[12];
         {outputSourceStationPinsN, directionSplitSelect, polaritySelect, longFrameSelectN} <= d[17:0];
         {outputHalfSelectN, directionSwapN, externalIoIn} <= d[63:30];
         repeat (3) @(posedge ref_clk);
         peer.send(~outputSourceStationPinsN, d, 1);
         `CHK(txValid, 1'b1)
         `CHK(txBlock, expBlk())
         `CHK(internalOutputs, outputHalfSelectN ? d[31:0] : d[63:32])
         @(posedge ref_clk);
         peer.send(~outputSourceStationPinsN ^ 6'h01, ~d, 0);
         `CHK(internalOutputs, outputHalfSelectN ? d[31:0] : d[63:32])
         @(posedge ref_clk);
      end
      avs(0, 5'h0c, 0);
      `CHK(q, outputHalfSelectN ? d[31:0] : d[63:32])
      d = expBlk();
      avs(0, 5'h08, 0);
      `CHK(q, d[63:32])
      resetRun();
      tally_and_finish();
   end
endmodule
